// file: rtl/adc_regs_pkg.sv
// constants and carrier types shared by the converter register bank
// assumes one clock, the digital master clock, and byte addressing on the bus
package adc_regs_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_STATUS = 8'h0a;
   localparam logic [7:0] IDX_SETTINGS = 8'h0c;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
   localparam logic [7:0] ADDR_SETTINGS = {IDX_SETTINGS[5:0], 2'b00};
   localparam logic [7:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
   localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

   // reset values and writable-bit masks
   localparam logic [15:0] STATUS_RESET = 16'h03b8;
   localparam logic [15:0] STATUS_WMASK = 16'hdcfe;
   localparam logic [15:0] SETTINGS_RESET = 16'h1e02;
   localparam logic [15:0] SETTINGS_WMASK = 16'hfff6;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // gain correction group delay in digital master clock periods
   localparam int GAIN_DELAY_CYCLES = 24;
   localparam int WORD_BITS = 24;
   localparam int SHORT_BITS = 16;

   // address loop limits: data, settings, calibration
   localparam logic [7:0] DATA_LAST = 8'h05;
   localparam logic [7:0] SET_LAST = 8'h0d;
   localparam logic [7:0] MAP_LAST = 8'h1a;
   localparam logic [7:0] SET_FIRST = 8'h06;
   localparam logic [7:0] CAL_FIRST = 8'h0e;

   typedef enum logic [1:0] {
      W_BOTH16 = 2'b00, W_CH0_24 = 2'b01, W_CH1_24 = 2'b10, W_BOTH24 = 2'b11
   } width_mode_t;

   typedef enum logic [1:0] {
      SRC_LAG = 2'b00, SRC_CH0 = 2'b01, SRC_CH1 = 2'b10, SRC_BOTH = 2'b11
   } src_mode_t;

   typedef enum logic [1:0] {
      LOOP_STATIC = 2'b00, LOOP_GROUP = 2'b01, LOOP_TYPES = 2'b10, LOOP_MAP = 2'b11
   } loop_mode_t;

   typedef struct packed {
      logic [1:0] modulator_output_select;
      logic unused13;
      logic ready_pin_float_ctrl;
      src_mode_t ready_pin_source_mode;
      logic [1:0] ready_flags;
      loop_mode_t read_loop;
      logic write_loop;
      width_mode_t width;
      logic offset_correction_on;
      logic gain_correction_on;
      logic unused0;
   } status_reg_t;

   typedef struct packed {
      logic [1:0] prescale;
      logic [2:0] oversampling_ratio_sel;
      logic [1:0] dither;
      logic autozero_rate;
      logic [1:0] chan_reset;
      logic [1:0] chan_shutdown;
      logic unused3;
      logic internal_reference_off;
      logic external_clock_select;
      logic unused0;
   } settings_reg_t;

   // per-channel pulse pair, bit 1 is channel 1
   typedef struct packed {
      logic ch1;
      logic ch0;
   } chan_pair_t;

   // sticky event bits
   typedef struct packed {
      logic pin_pulse;
      logic ch1;
      logic ch0;
   } irq_bits_t;
endpackage

// file: rtl/adc_status_comm_config_regs.sv
// status, link control and settings registers of a two-channel converter
// assumes Avalon-MM master on i_clk, ready pulses and data words from the filters
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module adc_status_comm_config_regs (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire adc_regs_pkg::chan_pair_t i_ready_pulse,
   input wire adc_regs_pkg::chan_pair_t i_data_taken,
   input wire logic [23:0] i_ch0_data,
   input wire logic [23:0] i_ch1_data,
   input wire logic i_loop_load,
   input wire logic i_loop_step,
   input wire logic i_loop_write,
   input wire logic [7:0] i_loop_start,
   output logic [7:0] o_loop_addr,
   output logic [23:0] o_ch0_word,
   output logic [23:0] o_ch1_word,
   output logic o_data_ready_pin_o,
   output logic o_data_ready_pin_oe,
   output adc_regs_pkg::chan_pair_t o_modulator_data_pins_on,
   output adc_regs_pkg::chan_pair_t o_filter_off,
   output logic o_offset_correction_on,
   output logic o_gain_correction_on,
   output adc_regs_pkg::settings_reg_t o_settings,
   output logic o_irq
);
   typedef struct packed {
      adc_regs_pkg::status_reg_t stat;
      adc_regs_pkg::settings_reg_t set;
      adc_regs_pkg::irq_bits_t irq_stat;
      adc_regs_pkg::irq_bits_t irq_mask;
      logic ack;
      logic [31:0] rdata;
      adc_regs_pkg::chan_pair_t seen;
      logic pin_pulse;
      logic [23:0] word0;
      logic [23:0] word1;
      logic [7:0] addr;
   } state_t;

   state_t st;
   state_t next_st;
   adc_regs_pkg::chan_pair_t delayed;
   adc_regs_pkg::chan_pair_t live;
   logic [15:0] wmask;
   logic pin_fire;
   logic wr_hit;

   // byte enables expand to a bit mask over the low half word
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // merge a write under writable and byte-lane masks
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
         input logic [15:0] m);
      merge16 = (old & ~m) | (val & m);
   endfunction

   // width code shortens a channel word to its top 16 bits
   function automatic logic [23:0] shape(input logic [23:0] d, input logic full);
      shape = full ? d : {8'h00, d[23:8]};
   endfunction

   // end of the span that holds addr, by loop mode
   function automatic logic [7:0] span_last(input adc_regs_pkg::loop_mode_t m,
         input logic [7:0] a);
      span_last = adc_regs_pkg::MAP_LAST;
      if (m == adc_regs_pkg::LOOP_TYPES || m == adc_regs_pkg::LOOP_GROUP) begin
         if (a <= adc_regs_pkg::DATA_LAST) begin
            span_last = adc_regs_pkg::DATA_LAST;
         end else if (a <= adc_regs_pkg::SET_LAST) begin
            span_last = adc_regs_pkg::SET_LAST;
         end
      end
   endfunction

   function automatic logic [7:0] span_first(input adc_regs_pkg::loop_mode_t m,
         input logic [7:0] a);
      span_first = 8'h00;
      if (m == adc_regs_pkg::LOOP_TYPES || m == adc_regs_pkg::LOOP_GROUP) begin
         if (a > adc_regs_pkg::SET_LAST) begin
            span_first = adc_regs_pkg::CAL_FIRST;
         end else if (a > adc_regs_pkg::DATA_LAST) begin
            span_first = adc_regs_pkg::SET_FIRST;
         end
      end
   endfunction

   // step of the continuous access counter
   function automatic logic [7:0] next_addr(input adc_regs_pkg::loop_mode_t m,
         input logic [7:0] a);
      if (m == adc_regs_pkg::LOOP_STATIC) begin
         next_addr = a;
      end else if (a >= span_last(m, a)) begin
         next_addr = span_first(m, a);
      end else begin
         next_addr = a + 8'h01;
      end
   endfunction

   // gain correction delays both ready pulses by the group delay
   ready_pulse_delay #(
      .DEPTH(adc_regs_pkg::GAIN_DELAY_CYCLES)
   ) u_delay (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_pulse(i_ready_pulse),
      .i_delay_on(st.stat.gain_correction_on),
      .o_pulse(delayed)
   );

   // a channel whose filter is off produces no ready pulses
   assign live.ch0 = delayed.ch0 & ~st.stat.modulator_output_select[0];
   assign live.ch1 = delayed.ch1 & ~st.stat.modulator_output_select[1];
   assign wmask = lane_mask(i_avs_byteenable);
   assign wr_hit = i_avs_write && st.ack;

   // pin pulse selection by source mode
   always_comb begin
      unique case (st.stat.ready_pin_source_mode)
         adc_regs_pkg::SRC_BOTH: pin_fire = live.ch0 | live.ch1;
         adc_regs_pkg::SRC_CH0: pin_fire = live.ch0;
         adc_regs_pkg::SRC_CH1: pin_fire = live.ch1;
         adc_regs_pkg::SRC_LAG: pin_fire = (st.seen.ch0 | live.ch0) & (st.seen.ch1 | live.ch1);
      endcase
   end

   // next state: bus access, flags, words, pin and loop counter
   always_comb begin
      next_st = st;
      next_st.pin_pulse = pin_fire;
      // lagging mode waits for both channels since the last pin pulse
      if (pin_fire) begin
         next_st.seen = '0;
      end else begin
         next_st.seen = st.seen | live;
      end
      // one wait state: ack rises for a single cycle per request
      next_st.ack = (i_avs_read || i_avs_write) && !st.ack;
      if (i_avs_read && !st.ack) begin
         next_st.rdata = 32'h0000_0000;
         unique case (i_avs_address)
            adc_regs_pkg::ADDR_STATUS: next_st.rdata[15:0] = st.stat & 16'hdffe;
            adc_regs_pkg::ADDR_SETTINGS: next_st.rdata[15:0] = st.set & 16'hfff6;
            adc_regs_pkg::ADDR_IRQ_STAT: next_st.rdata[2:0] = st.irq_stat;
            adc_regs_pkg::ADDR_IRQ_MASK: next_st.rdata[2:0] = st.irq_mask;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      // writes land at the edge where waitrequest is low
      if (wr_hit && i_avs_address == adc_regs_pkg::ADDR_STATUS) begin
         next_st.stat = merge16(st.stat, i_avs_writedata[15:0],
            wmask & adc_regs_pkg::STATUS_WMASK);
      end
      if (wr_hit && i_avs_address == adc_regs_pkg::ADDR_SETTINGS) begin
         next_st.set = merge16(st.set, i_avs_writedata[15:0],
            wmask & adc_regs_pkg::SETTINGS_WMASK);
      end
      if (wr_hit && i_avs_address == adc_regs_pkg::ADDR_IRQ_MASK && i_avs_byteenable[0]) begin
         next_st.irq_mask = i_avs_writedata[2:0];
      end
      // write one to clear, a new event in the same cycle wins
      if (wr_hit && i_avs_address == adc_regs_pkg::ADDR_IRQ_STAT && i_avs_byteenable[0]) begin
         next_st.irq_stat = st.irq_stat & ~i_avs_writedata[2:0];
      end
      next_st.irq_stat = next_st.irq_stat | {pin_fire, live.ch1, live.ch0};
      // flags read low while data waits; a new pulse beats a take
      if (i_data_taken.ch0) begin
         next_st.stat.ready_flags[0] = 1'b1;
      end
      if (i_data_taken.ch1) begin
         next_st.stat.ready_flags[1] = 1'b1;
      end
      if (live.ch0) begin
         next_st.stat.ready_flags[0] = 1'b0;
         next_st.word0 = shape(i_ch0_data, st.stat.width[0]);
      end
      if (live.ch1) begin
         next_st.stat.ready_flags[1] = 1'b0;
         next_st.word1 = shape(i_ch1_data, st.stat.width[1]);
      end
      // continuous access counter; writes loop the map or hold
      if (i_loop_load) begin
         next_st.addr = i_loop_start;
      end else if (i_loop_step && i_loop_write) begin
         next_st.addr = next_addr(st.stat.write_loop ? adc_regs_pkg::LOOP_MAP
            : adc_regs_pkg::LOOP_STATIC, st.addr);
      end else if (i_loop_step) begin
         next_st.addr = next_addr(st.stat.read_loop, st.addr);
      end
   end

   // synchronous reset to the power-on values
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= '0;
         st.stat <= adc_regs_pkg::STATUS_RESET;
         st.set <= adc_regs_pkg::SETTINGS_RESET;
         st.irq_stat <= adc_regs_pkg::IRQ_RESET;
         st.irq_mask <= adc_regs_pkg::IRQ_RESET;
      end else begin
         st <= next_st;
      end
   end

   // bus answers
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st.ack;
   assign o_avs_readdata = st.rdata;

   // pin idles floating or driven high, pulses low for one cycle
   assign o_data_ready_pin_o = ~st.pin_pulse;
   assign o_data_ready_pin_oe = st.stat.ready_pin_float_ctrl | st.pin_pulse;

   // modulator routing turns off the matching filter
   assign o_modulator_data_pins_on.ch0 = st.stat.modulator_output_select[0];
   assign o_modulator_data_pins_on.ch1 = st.stat.modulator_output_select[1];
   assign o_filter_off = o_modulator_data_pins_on;

   // correction enables; offset correction adds no delay here
   assign o_offset_correction_on = st.stat.offset_correction_on;
   assign o_gain_correction_on = st.stat.gain_correction_on;
   assign o_settings = st.set & 16'hfff6;
   assign o_ch0_word = st.word0;
   assign o_ch1_word = st.word1;
   assign o_loop_addr = st.addr;
   assign o_irq = |(st.irq_stat & st.irq_mask);
endmodule // adc_status_comm_config_regs
`default_nettype wire

// file: rtl/ready_pulse_delay.sv
// fixed delay line for the two channels' ready pulses
// assumes pulses come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module ready_pulse_delay #(
   parameter int DEPTH = 24
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire adc_regs_pkg::chan_pair_t i_pulse,
   input wire logic i_delay_on,
   output adc_regs_pkg::chan_pair_t o_pulse
);
   typedef struct packed {
      logic [DEPTH-1:0] line0;
      logic [DEPTH-1:0] line1;
      adc_regs_pkg::chan_pair_t out;
   } dstate_t;

   dstate_t st;
   dstate_t next_st;

   // only delayed pulses enter the line, so turning the delay on never replays one
   // pulses still in flight when the delay turns off leave at their own time
   always_comb begin
      next_st = st;
      next_st.line0 = {st.line0[DEPTH-2:0], i_pulse.ch0 & i_delay_on};
      next_st.line1 = {st.line1[DEPTH-2:0], i_pulse.ch1 & i_delay_on};
      if (i_delay_on) begin
         next_st.out.ch0 = st.line0[DEPTH-1];
         next_st.out.ch1 = st.line1[DEPTH-1];
      end else begin
         next_st.out.ch0 = i_pulse.ch0 | st.line0[DEPTH-1];
         next_st.out.ch1 = i_pulse.ch1 | st.line1[DEPTH-1];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_pulse = st.out;
endmodule // ready_pulse_delay
`default_nettype wire

// file: tb/adc_regs_monitor.sv
// port checker for the converter register bank
// assumes it is bound onto the bank and shares its one clock and reset
`timescale 1ns/10ps
`default_nettype none
module adc_regs_monitor (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire adc_regs_pkg::chan_pair_t i_ready_pulse,
   input wire logic [23:0] i_ch0_data,
   input wire logic [23:0] o_ch0_word,
   input wire logic o_data_ready_pin_o,
   input wire adc_regs_pkg::chan_pair_t o_filter_off,
   input wire logic o_gain_correction_on,
   input wire adc_regs_pkg::settings_reg_t o_settings
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   // the width mode is not at the ports, so either word form is accepted
   function automatic logic word_ok(input logic [23:0] w, input logic [23:0] d);
      return (w == d) || (w == {8'h00, d[23:8]});
   endfunction

   chk_one_wait: assert property ($rose(i_avs_read || i_avs_write)
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait not one cycle");
   chk_status_bit0: assert property (i_avs_read && !o_avs_waitrequest
      && i_avs_address == adc_regs_pkg::ADDR_STATUS |-> !o_avs_readdata[0])
      else $error("status bit 0 read as one");
   chk_settings_gaps: assert property (!o_settings.unused3 && !o_settings.unused0)
      else $error("settings gap bit set");
   chk_reset_values: assert property ($rose(i_rstn) |-> o_avs_readdata == 32'h0
      && o_settings == adc_regs_pkg::SETTINGS_RESET && !o_gain_correction_on)
      else $error("bad values after reset");
   chk_word_direct: assert property (i_ready_pulse.ch0 && !o_gain_correction_on
      && !o_filter_off.ch0 |-> ##2 word_ok(o_ch0_word, $past(i_ch0_data)))
      else $error("word not taken after ready pulse");
   chk_gain_late: assert property (i_ready_pulse.ch0 && o_gain_correction_on
      && !o_filter_off.ch0 |-> ##26 word_ok(o_ch0_word, $past(i_ch0_data)))
      else $error("gain delayed word wrong");
   chk_gain_hold: assert property (i_ready_pulse.ch0 && o_gain_correction_on
      |=> $stable(o_ch0_word) [*8]) else $error("gain delay missing");
   chk_filter_stop: assert property (o_filter_off.ch0 && !o_gain_correction_on
      |=> $stable(o_ch0_word)) else $error("word moved with filter off");
   chk_pin_pulse: assert property ($fell(o_data_ready_pin_o) |=> o_data_ready_pin_o)
      else $error("pin pulse longer than one cycle");
endmodule // adc_regs_monitor

bind adc_status_comm_config_regs adc_regs_monitor mon_u (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_ready_pulse(i_ready_pulse), .i_ch0_data(i_ch0_data), .o_ch0_word(o_ch0_word),
   .o_data_ready_pin_o(o_data_ready_pin_o), .o_filter_off(o_filter_off),
   .o_gain_correction_on(o_gain_correction_on), .o_settings(o_settings));
`default_nettype wire

// file: tb/adc_status_comm_config_regs_test.sv
// self-checking bench for the converter register bank
// assumes the host model drives the bus and the bench plays the filters
`timescale 1ns/10ps
`default_nettype none
module adc_status_comm_config_regs_test;
   logic i_clk, i_rstn, rd_en, wr_en, waitreq, load, step, pin_o, pin_oe, off_on, gain_on, irq;
   logic lwr;
   logic [7:0] addr, start, laddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] ben;
   logic [23:0] d0, d1, w0, w1;
   adc_regs_pkg::chan_pair_t pulse, taken, mod_on, foff;
   adc_regs_pkg::settings_reg_t sets;
   int err_total, checked, pin_lows, n;
   // status word and pin pulses expected for ch0, ch0, ch1
   logic [19:0] rows [4] = '{{16'h0000, 4'd1}, {16'h0408, 4'd2}, {16'h0810, 4'd1},
      {16'h0c18, 4'd3}};

   avalon_host_model host_u (.i_clk(i_clk), .i_waitrequest(waitreq), .i_readdata(rdata),
      .o_address(addr), .o_read(rd_en), .o_write(wr_en), .o_writedata(wdata),
      .o_byteenable(ben));
   adc_status_comm_config_regs dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(addr),
      .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
      .i_avs_byteenable(ben), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_ready_pulse(pulse), .i_data_taken(taken), .i_ch0_data(d0), .i_ch1_data(d1),
      .i_loop_load(load), .i_loop_step(step), .i_loop_write(lwr), .i_loop_start(start),
      .o_loop_addr(laddr), .o_ch0_word(w0), .o_ch1_word(w1), .o_data_ready_pin_o(pin_o),
      .o_data_ready_pin_oe(pin_oe), .o_modulator_data_pins_on(mod_on), .o_filter_off(foff),
      .o_offset_correction_on(off_on), .o_gain_correction_on(gain_on), .o_settings(sets),
      .o_irq(irq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d of %0d checks", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host_u.xfer(1'b1, a, d, v);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      host_u.xfer(1'b0, a, 16'h0000, v);
      check(v, {16'h0000, e});
   endtask
   // one-cycle ready pulse, returns at the edge that samples it
   task automatic fire(input logic [1:0] p);
      @(posedge i_clk);
      pulse <= p;
      @(posedge i_clk);
      pulse <= 2'b00;
   endtask
   task automatic lstep(input logic [7:0] s);
      @(posedge i_clk);
      start <= s;
      load <= 1'b1;
      @(posedge i_clk);
      load <= 1'b0;
      step <= 1'b1;
      @(posedge i_clk);
      step <= 1'b0;
      tick(1);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // pin is driven low for each shown pulse
   always @(posedge i_clk) if (pin_oe && !pin_o) pin_lows <= pin_lows + 1;
   // the run needs under 2000 cycles
   initial begin
      #500000;
      err_total++;
      wrap_up();
   end

   initial begin
      {i_rstn, load, step, lwr, pulse, taken, start} = '0;
      d0 = 24'habcdef;
      d1 = 24'h123456;
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      tick(1);
      check(sets, adc_regs_pkg::SETTINGS_RESET);
      check({pin_o, pin_oe, irq, gain_on, off_on}, 5'b10000);
      rd_chk(adc_regs_pkg::ADDR_STATUS, 16'h03b8);
      wr(adc_regs_pkg::ADDR_SETTINGS, 16'hffff);
      rd_chk(adc_regs_pkg::ADDR_SETTINGS, 16'hfff6);
      wr(adc_regs_pkg::ADDR_STATUS, 16'hffff);
      tick(1);
      check({foff, mod_on, pin_oe}, 5'h1f);
      rd_chk(adc_regs_pkg::ADDR_STATUS, 16'hdffe);
      wr(adc_regs_pkg::ADDR_STATUS, 16'h0000);
      rd_chk(adc_regs_pkg::ADDR_STATUS, 16'h0300);
      wr(8'h3c, 16'hffff);
      rd_chk(8'h3c, 16'h0000);
      wr(adc_regs_pkg::ADDR_IRQ_MASK, 16'h0007);
      rd_chk(adc_regs_pkg::ADDR_IRQ_MASK, 16'h0007);
      // widths and pin sources share one index
      for (int i = 0; i < 4; i++) begin
         n = pin_lows;
         wr(adc_regs_pkg::ADDR_STATUS, rows[i][19:4]);
         fire(2'b01);
         tick(3);
         fire(2'b01);
         tick(3);
         fire(2'b10);
         tick(4);
         check(pin_lows - n, rows[i][3:0]);
         check(w0, i[0] ? d0 : {8'h00, d0[23:8]});
         check(w1, i[1] ? d1 : {8'h00, d1[23:8]});
         rd_chk(adc_regs_pkg::ADDR_STATUS, rows[i][19:4]);
         @(posedge i_clk);
         taken <= 2'b11;
         @(posedge i_clk);
         taken <= 2'b00;
         rd_chk(adc_regs_pkg::ADDR_STATUS, rows[i][19:4] | 16'h0300);
      end
      // masked event stays quiet, clearing one bit keeps the others
      wr(adc_regs_pkg::ADDR_IRQ_STAT, 16'h0007);
      wr(adc_regs_pkg::ADDR_IRQ_MASK, 16'h0001);
      fire(2'b10);
      tick(3);
      check(irq, 1'b0);
      fire(2'b01);
      tick(3);
      check(irq, 1'b1);
      wr(adc_regs_pkg::ADDR_IRQ_STAT, 16'h0001);
      tick(1);
      check(irq, 1'b0);
      rd_chk(adc_regs_pkg::ADDR_IRQ_STAT, 16'h0006);
      // offset adds no delay, gain adds exactly 24 cycles
      wr(adc_regs_pkg::ADDR_STATUS, 16'h0004);
      d0 <= 24'h5a5a5a;
      fire(2'b01);
      tick(1);
      check({off_on, w0}, {1'b1, 24'h005a5a});
      wr(adc_regs_pkg::ADDR_STATUS, 16'h0002);
      d0 <= 24'h3c3c3c;
      fire(2'b01);
      tick(24);
      check({gain_on, w0}, {1'b1, 24'h005a5a});
      tick(1);
      check(w0, 24'h003c3c);
      wr(adc_regs_pkg::ADDR_STATUS, 16'h4000);
      d0 <= 24'h111111;
      tick(1);
      check(foff, 2'b01);
      fire(2'b01);
      tick(2);
      check(w0, 24'h003c3c);
      lstep(8'h07);
      check(laddr, 8'h07);
      wr(adc_regs_pkg::ADDR_STATUS, 16'h00c0);
      lstep(8'h1a);
      check(laddr, 8'h00);
      // register types loop wraps inside the settings span
      wr(adc_regs_pkg::ADDR_STATUS, 16'h0080);
      lstep(8'h0d);
      check(laddr, 8'h06);
      // write steps loop the whole map when the write loop bit is set
      wr(adc_regs_pkg::ADDR_STATUS, 16'h0020);
      lwr <= 1'b1;
      lstep(8'h1a);
      check(laddr, 8'h00);
      lwr <= 1'b0;
      // second reset in mid-run
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      tick(1);
      check(sets, adc_regs_pkg::SETTINGS_RESET);
      rd_chk(adc_regs_pkg::ADDR_STATUS, 16'h03b8);
      wrap_up();
   end
endmodule // adc_status_comm_config_regs_test
`default_nettype wire

// file: tb/avalon_host_model.sv
// register bus master standing in for the host controller
// assumes a slave that answers by lowering waitrequest on the same clock
`timescale 1ns/10ps
`default_nettype none
module avalon_host_model (
   input wire logic i_clk,
   input wire logic i_waitrequest,
   input wire logic [31:0] i_readdata,
   output logic [7:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   output logic [3:0] o_byteenable
);
   // idle bus at time zero; lanes 0 and 1 carry the 16-bit registers
   initial begin
      o_address = 8'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'h3;
   end

   // hold the request until waitrequest is seen low at an edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] q);
      @(posedge i_clk);
      o_address <= a;
      o_read <= !wr;
      o_write <= wr;
      o_writedata <= {16'h0000, d};
      do @(posedge i_clk); while (i_waitrequest !== 1'b0);
      q = i_readdata;
      o_read <= 1'b0;
      o_write <= 1'b0;
   endtask
endmodule // avalon_host_model
`default_nettype wire
